// ===== hw/aid_params.svh
// Constants of the external aiding packet decoder: identifiers, lengths, offsets.
// Assumes packet framing is done upstream; the decoder itself checks header identifier and length.
// Function
// [R1] Identifier 44, 60 bytes, read and write.
// [R2] Packet 44: three fp64, nine fp32 from 24.
// [R3] Identifier 45, 36 bytes, read and write.
// [R4] Packet 45: three fp64, sd at 24-32.
// [R5] Sender gives strictly positive position deviations.
// [R6] Identifier 46, 24 bytes, read and write.
// [R7] Packet 46: six fp32, offsets 0 to 20.
// [R8] Identifier 47, 16 or 24 bytes.
// [R9] Sender sets length 16 or 24 by format.
// [R10] Short packet 47: one deviation, all axes.
// [R11] Packet 47: velocities 0-8, deviations 12-20.
// [R12] Identifier 48, 8 bytes, read and write.
// [R13] Packet 48: heading at 0, deviation at 4.
// [R14] Wrong length packets are discarded, no update.
// [R15] Floats are IEEE-754, least significant byte first.
`ifndef AID_PARAMS_SVH
`define AID_PARAMS_SVH

// ----------------------------------------------------------------------------
// Identifiers and payload lengths
// ----------------------------------------------------------------------------
`define AID_ID_POSVEL   8'h2C
`define AID_ID_POS      8'h2D
`define AID_ID_VEL      8'h2E
`define AID_ID_BODY     8'h2F
`define AID_ID_HDG      8'h30
`define AID_LEN_POSVEL  8'h3C
`define AID_LEN_POS     8'h24
`define AID_LEN_VEL     8'h18
`define AID_LEN_BODY_S  8'h10
`define AID_LEN_BODY_L  8'h18
`define AID_LEN_HDG     8'h08
`define AID_MAX_LEN     8'h3C
`define AID_NUM_KINDS   8'h05

// ----------------------------------------------------------------------------
// Field offsets, strides and record slots
// ----------------------------------------------------------------------------
`define AID_OFS_POS     8'h00
`define AID_OFS_PV_F32  8'h18
`define AID_OFS_VEL     8'h00
`define AID_OFS_VELSD   8'h0C
`define AID_OFS_HDG     8'h00
`define AID_OFS_HDG_SD  8'h04
`define AID_F64_STEP    8'h08
`define AID_F32_STEP    8'h04
`define AID_N_F64       8'h03
`define AID_N_F32       8'h09
`define AID_N_AXES      8'h03
`define AID_SLOT_VEL    8'h00
`define AID_SLOT_POSSD  8'h03
`define AID_SLOT_VELSD  8'h06
`define AID_BUF_DEPTH   2'h2

`endif

// ===== hw/aid_pkg.sv
// Types shared by the aiding packet decoder and its output buffer.
// Assumes aid_params.svh is on the include path.
`include "aid_params.svh"

package aid_pkg;
    typedef enum logic [2:0] {AK_POSVEL, AK_POS, AK_VEL, AK_BODY, AK_HDG} aid_kind_t;

    typedef logic [7:0] aid_img_t [`AID_MAX_LEN];

    // Slots 0-2 velocity or heading, 3-5 position deviation, 6-8 velocity or heading deviation.
    typedef struct packed {
        aid_kind_t          kind;
        logic [2:0][63:0]   pos;
        logic [8:0][31:0]   f32;
    } aid_rec_t;
endpackage : aid_pkg

// ===== hw/aid_stream_if.sv
// Valid and ready carrier for decoded aiding records between decoder and buffer.
// Assumes both ends share one clock.
interface aid_stream_if;
    logic               valid;
    logic               ready;
    aid_pkg::aid_rec_t  data;

    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface : aid_stream_if

// ===== hw/aid_buf2.sv
// Two-entry buffer for decoded records in front of the navigation filter.
// Assumes a single clock and a synchronous active-high reset.
`include "aid_params.svh"

module aid_buf2 (
    // Clock and reset
    input  wire logic               clk,
    input  wire logic               rst,
    // Filling side
    aid_stream_if.snk               up,
    // Draining side
    output      logic               out_valid,
    input  wire logic               out_ready,
    output      aid_pkg::aid_rec_t  out_data
);
    aid_pkg::aid_rec_t  mem_q [2];
    logic               wp_q;
    logic               rp_q;
    logic [1:0]         cnt_q;
    logic               push;
    logic               pop;

    // A full buffer withdraws ready, so a stalled filter loses no record.
    assign up.ready  = (cnt_q != `AID_BUF_DEPTH);
    assign out_valid = (cnt_q != 2'h0);
    assign out_data  = mem_q[rp_q];
    assign push      = up.valid && up.ready;
    assign pop       = out_valid && out_ready;

    always_ff @(posedge clk) begin
        if (rst) begin
            wp_q  <= 1'b0;
            rp_q  <= 1'b0;
            cnt_q <= 2'h0;
        end else begin
            if (push) begin
                mem_q[wp_q] <= up.data;
                wp_q        <= ~wp_q;
            end
            if (pop) begin
                rp_q <= ~rp_q;
            end
            cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
        end
    end

    buf_full_a: assert property (@(posedge clk) disable iff (rst)
        (cnt_q == `AID_BUF_DEPTH) |-> !up.ready) else $error("Full buffer still ready.");
    buf_hold_a: assert property (@(posedge clk) disable iff (rst)
        (out_valid && !out_ready) |=> (out_valid && $stable(out_data)))
        else $error("Stalled record changed or vanished.");
endmodule : aid_buf2

// ===== hw/aid_decoder.sv
// Decoder for the five external aiding packets: write path to the filter, read-back path.
// Assumes upstream framing delivers one header, then exactly the header length of bytes.
`include "aid_params.svh"

module aid_decoder (
    // Clock and reset
    input  wire logic               clk,
    input  wire logic               rst,
    // Packet header
    input  wire logic               hdr_valid,
    output      logic               hdr_ready,
    input  wire logic [7:0]         hdr_id,
    input  wire logic [7:0]         hdr_len,
    // Payload bytes
    input  wire logic               rx_valid,
    output      logic               rx_ready,
    input  wire logic [7:0]         rx_data,
    // Read-back request
    input  wire logic               rd_valid,
    output      logic               rd_ready,
    input  wire logic [7:0]         rd_id,
    // Read-back payload
    output      logic               tx_valid,
    input  wire logic               tx_ready,
    output      logic [7:0]         tx_data,
    output      logic               tx_last,
    output      logic [7:0]         tx_len,
    // Filter update
    output      logic               upd_valid,
    input  wire logic               upd_ready,
    output      aid_pkg::aid_rec_t  upd_data,
    // Status
    output      logic               drop_pulse
);
    // ------------------------------------------------------------------------
    // Decoding helpers
    // ------------------------------------------------------------------------
    function automatic logic id_known(input logic [7:0] id);
        return (id >= `AID_ID_POSVEL) && (id <= `AID_ID_HDG);
    endfunction : id_known

    function automatic aid_pkg::aid_kind_t kind_of(input logic [7:0] id);
        logic [7:0] d;
        d = id - `AID_ID_POSVEL;
        return aid_pkg::aid_kind_t'(d[2:0]);
    endfunction : kind_of

    function automatic logic len_allowed(input aid_pkg::aid_kind_t k, input logic [7:0] len);
        logic ok;
        ok = 1'b0;
        case (k)
            aid_pkg::AK_POSVEL: ok = (len == `AID_LEN_POSVEL);                 // [R1]
            aid_pkg::AK_POS:    ok = (len == `AID_LEN_POS);                    // [R3]
            aid_pkg::AK_VEL:    ok = (len == `AID_LEN_VEL);                    // [R6]
            aid_pkg::AK_BODY:   ok = (len == `AID_LEN_BODY_S) ||
                                     (len == `AID_LEN_BODY_L);                 // [R8]
            aid_pkg::AK_HDG:    ok = (len == `AID_LEN_HDG);                    // [R12]
            default:            ok = 1'b0;
        endcase
        return ok;
    endfunction : len_allowed

    // Least significant byte first on the wire.
    function automatic logic [31:0] get32(input aid_pkg::aid_img_t b, input int o);
        return {b[o+3], b[o+2], b[o+1], b[o]};                                // [R15]
    endfunction : get32

    function automatic logic [63:0] get64(input aid_pkg::aid_img_t b, input int o);
        return {get32(b, o + 4), get32(b, o)};                                // [R15]
    endfunction : get64

    function automatic aid_pkg::aid_rec_t rec_build(input aid_pkg::aid_kind_t k,
                                                     input logic sh,
                                                     input aid_pkg::aid_img_t b);
        aid_pkg::aid_rec_t r;
        r      = '0;
        r.kind = k;
        case (k)
            aid_pkg::AK_POSVEL: begin
                for (int i = 0; i < `AID_N_F64; i++)
                    r.pos[i] = get64(b, `AID_OFS_POS + i * `AID_F64_STEP);         // [R2]
                for (int i = 0; i < `AID_N_F32; i++)
                    r.f32[i] = get32(b, `AID_OFS_PV_F32 + i * `AID_F32_STEP);      // [R2]
            end
            aid_pkg::AK_POS: begin
                for (int i = 0; i < `AID_N_AXES; i++) begin
                    r.pos[i] = get64(b, `AID_OFS_POS + i * `AID_F64_STEP);         // [R4]
                    r.f32[`AID_SLOT_POSSD + i] =
                        get32(b, `AID_OFS_PV_F32 + i * `AID_F32_STEP);             // [R4]
                end
            end
            aid_pkg::AK_VEL, aid_pkg::AK_BODY: begin
                for (int i = 0; i < `AID_N_AXES; i++) begin
                    r.f32[`AID_SLOT_VEL + i] =
                        get32(b, `AID_OFS_VEL + i * `AID_F32_STEP);                // [R7] [R11]
                    r.f32[`AID_SLOT_VELSD + i] = sh ? get32(b, `AID_OFS_VELSD) :   // [R10]
                        get32(b, `AID_OFS_VELSD + i * `AID_F32_STEP);              // [R7] [R11]
                end
            end
            aid_pkg::AK_HDG: begin
                r.f32[`AID_SLOT_VEL]   = get32(b, `AID_OFS_HDG);                   // [R13]
                r.f32[`AID_SLOT_VELSD] = get32(b, `AID_OFS_HDG_SD);                // [R13]
            end
            default: r = '0;
        endcase
        return r;
    endfunction : rec_build

    // ------------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------------
    typedef enum logic [1:0] {ST_IDLE, ST_COLLECT, ST_EMIT, ST_READ} aid_state_t;

    aid_state_t          st_q;
    aid_pkg::aid_kind_t  kind_q;
    logic [7:0]          len_q;
    logic [7:0]          idx_q;
    logic                ok_q;
    logic                drop_q;
    logic [7:0]          tx_data_q;
    aid_pkg::aid_img_t   sc_q;
    logic [7:0]          img_q [`AID_NUM_KINDS][`AID_MAX_LEN];
    logic [7:0]          img_len_q [`AID_NUM_KINDS];
    logic                img_ok_q [`AID_NUM_KINDS];

    aid_stream_if        up ();

    wire                 hdr_fire = hdr_valid && hdr_ready;
    wire                 rx_fire  = rx_valid && rx_ready;
    wire                 rd_fire  = rd_valid && rd_ready;
    wire                 tx_fire  = tx_valid && tx_ready;
    wire                 rx_end   = (idx_q == len_q - 8'h01);
    wire                 in_img   = (idx_q < `AID_MAX_LEN);
    wire [7:0]           idx_nx   = idx_q + 8'h01;
    wire aid_pkg::aid_kind_t hdr_k = kind_of(hdr_id);
    wire aid_pkg::aid_kind_t rd_k  = kind_of(rd_id);
    wire                 hdr_ok   = id_known(hdr_id) && len_allowed(hdr_k, hdr_len);
    wire                 rd_hit   = id_known(rd_id) && img_ok_q[rd_k];
    wire                 body_sh  = (len_q == `AID_LEN_BODY_S);

    // Header wins over a read request offered in the same cycle.
    assign hdr_ready  = (st_q == ST_IDLE);
    assign rd_ready   = (st_q == ST_IDLE) && !hdr_valid;
    assign rx_ready   = (st_q == ST_COLLECT);
    assign tx_valid   = (st_q == ST_READ);
    assign tx_last    = tx_valid && rx_end;
    assign tx_data    = tx_data_q;
    assign tx_len     = len_q;
    assign drop_pulse = drop_q;
    assign up.valid   = (st_q == ST_EMIT);
    assign up.data    = rec_build(kind_q, body_sh, sc_q);

    // ------------------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            st_q      <= ST_IDLE;
            kind_q    <= aid_pkg::AK_POSVEL;
            len_q     <= 8'h00;
            idx_q     <= 8'h00;
            ok_q      <= 1'b0;
            drop_q    <= 1'b0;
            tx_data_q <= 8'h00;
            for (int k = 0; k < `AID_NUM_KINDS; k++) begin
                img_ok_q[k]  <= 1'b0;
                img_len_q[k] <= 8'h00;
            end
        end else begin
            drop_q <= hdr_fire && !hdr_ok;                                        // [R14]
            case (st_q)
                ST_IDLE: begin
                    if (hdr_fire && (hdr_len != 8'h00)) begin
                        st_q   <= ST_COLLECT;
                        kind_q <= hdr_k;
                        len_q  <= hdr_len;
                        idx_q  <= 8'h00;
                        ok_q   <= hdr_ok;
                    end else if (rd_fire && rd_hit) begin
                        st_q      <= ST_READ;
                        kind_q    <= rd_k;
                        len_q     <= img_len_q[rd_k];
                        idx_q     <= 8'h00;
                        tx_data_q <= img_q[rd_k][0];
                    end
                end
                ST_COLLECT: begin
                    if (rx_fire) begin
                        if (in_img) begin
                            sc_q[idx_q[5:0]] <= rx_data;
                        end
                        idx_q <= idx_nx;
                        if (rx_end) begin
                            st_q <= ok_q ? ST_EMIT : ST_IDLE;                      // [R14]
                        end
                    end
                end
                ST_EMIT: begin
                    if (up.ready) begin
                        st_q              <= ST_IDLE;
                        img_ok_q[kind_q]  <= 1'b1;
                        img_len_q[kind_q] <= len_q;
                        for (int i = 0; i < `AID_MAX_LEN; i++)
                            img_q[kind_q][i] <= sc_q[i];
                    end
                end
                ST_READ: begin
                    if (tx_fire) begin
                        idx_q <= idx_nx;
                        if (rx_end) begin
                            st_q <= ST_IDLE;
                        end else begin
                            tx_data_q <= img_q[kind_q][idx_nx[5:0]];
                        end
                    end
                end
                default: st_q <= ST_IDLE;
            endcase
        end
    end

    aid_buf2 u_buf (
        .clk       (clk),
        .rst       (rst),
        .up        (up),
        .out_valid (upd_valid),
        .out_ready (upd_ready),
        .out_data  (upd_data)
    );

    // ------------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------------
    sequence last_good_byte;
        rx_fire && rx_end && ok_q;
    endsequence

    sequence last_bad_byte;
        rx_fire && rx_end && !ok_q;
    endsequence

    emit_after_a: assert property (@(posedge clk) disable iff (rst)
        last_good_byte |=> up.valid) else $error("Good packet not emitted.");           // [R14]
    bad_drop_a: assert property (@(posedge clk) disable iff (rst)
        last_bad_byte |=> (st_q == ST_IDLE) ##1 !up.valid)
        else $error("Bad length packet reached the filter.");                        // [R14]
    len_posvel_a: assert property (@(posedge clk) disable iff (rst)
        (up.valid && kind_q == aid_pkg::AK_POSVEL) |-> len_q == `AID_LEN_POSVEL)
        else $error("Packet 44 emitted with wrong length.");                          // [R1]
    len_pos_a: assert property (@(posedge clk) disable iff (rst)
        (up.valid && kind_q == aid_pkg::AK_POS) |-> len_q == `AID_LEN_POS)
        else $error("Packet 45 emitted with wrong length.");                          // [R3]
    len_vel_a: assert property (@(posedge clk) disable iff (rst)
        (up.valid && kind_q == aid_pkg::AK_VEL) |-> len_q == `AID_LEN_VEL)
        else $error("Packet 46 emitted with wrong length.");                          // [R6]
    len_body_a: assert property (@(posedge clk) disable iff (rst)
        (up.valid && kind_q == aid_pkg::AK_BODY) |->
        (len_q == `AID_LEN_BODY_S || len_q == `AID_LEN_BODY_L))
        else $error("Packet 47 emitted with wrong length.");                          // [R8]
    len_hdg_a: assert property (@(posedge clk) disable iff (rst)
        (up.valid && kind_q == aid_pkg::AK_HDG) |-> len_q == `AID_LEN_HDG)
        else $error("Packet 48 emitted with wrong length.");                          // [R12]
    short_sd_a: assert property (@(posedge clk) disable iff (rst)
        (up.valid && kind_q == aid_pkg::AK_BODY && body_sh) |->
        (up.data.f32[`AID_SLOT_VELSD + 1] == up.data.f32[`AID_SLOT_VELSD] &&
         up.data.f32[`AID_SLOT_VELSD + 2] == up.data.f32[`AID_SLOT_VELSD]))
        else $error("Short body packet deviation not shared.");                       // [R10]
    read_back_a: assert property (@(posedge clk) disable iff (rst)
        (rd_fire && rd_hit) |=> (tx_valid && tx_len == $past(img_len_q[rd_k])))
        else $error("Read-back did not start with stored length.");                  // [R1]
endmodule : aid_decoder

// ===== verif/aid_host_model.sv
// Host model that writes aiding packets into the decoder over its header and byte channels.
// Assumes the decoder's ready outputs change only just after a rising clock edge.
module aid_host_model (
    // Clock
    input  wire logic       clk,
    // Header channel
    output      logic       hdr_valid,
    input  wire logic       hdr_ready,
    output      logic [7:0] hdr_id,
    output      logic [7:0] hdr_len,
    // Payload channel
    output      logic       rx_valid,
    input  wire logic       rx_ready,
    output      logic [7:0] rx_data
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        hdr_valid = 1'b0;
        hdr_id    = 8'h00;
        hdr_len   = 8'h00;
        rx_valid  = 1'b0;
        rx_data   = 8'h00;
    end

    // Bit 7 stays clear, so every float sent, deviations included, is positive and non-zero.
    function automatic logic [7:0] pb(input logic [7:0] id, input int i, input int salt);
        return {1'b0, 7'(int'(id) + 3 * i + 11 * salt)};
    endfunction : pb

    // Released hdr_id and rx_data show the inverse of their last value, so stale data never looks valid; hdr_len keeps its value.
    task automatic send(input logic [7:0] id, input logic [7:0] len, input int salt,
                        input bit slow);
        @(posedge clk);
        hdr_valid <= 1'b1;
        hdr_id    <= id;
        hdr_len   <= len;
        @(negedge clk);
        while (!hdr_ready) @(negedge clk);
        @(posedge clk);
        hdr_valid <= 1'b0;
        hdr_id    <= ~id;
        for (int i = 0; i < int'(len); i++) begin
            rx_valid <= 1'b1;
            rx_data  <= pb(id, i, salt);
            @(negedge clk);
            while (!rx_ready) @(negedge clk);
            @(posedge clk);
            if (slow) begin
                rx_valid <= 1'b0;
                rx_data  <= ~pb(id, i, salt);
                @(posedge clk);
            end
        end
        rx_valid <= 1'b0;
        rx_data  <= ~pb(id, int'(len) - 1, salt);
    endtask : send
endmodule : aid_host_model

// ===== verif/aid_decoder_test.sv
// Self-checking bench of the aiding packet decoder with a host model on its packet side.
// Assumes the design files under hw/ are compiled first.
`include "aid_params.svh"

module aid_decoder_test;
    timeunit 1ns;
    timeprecision 1ps;

    // ------------------------------------------------------------------------
    // Signals and instances
    // ------------------------------------------------------------------------
    logic              clk;
    logic              rst;
    logic              hdr_valid;
    logic              hdr_ready;
    logic [7:0]        hdr_id;
    logic [7:0]        hdr_len;
    logic              rx_valid;
    logic              rx_ready;
    logic [7:0]        rx_data;
    logic              rd_valid;
    logic              rd_ready;
    logic [7:0]        rd_id;
    logic              tx_valid;
    logic              tx_ready;
    logic [7:0]        tx_data;
    logic              tx_last;
    logic [7:0]        tx_len;
    logic              upd_valid;
    logic              upd_ready;
    aid_pkg::aid_rec_t upd_data;
    logic              drop_pulse;
    int                errors = 0;
    int                samples_checked = 0;
    int                cycles = 0;
    int                drops = 0;

    localparam logic [7:0] IDS [6] = '{`AID_ID_POSVEL, `AID_ID_POS, `AID_ID_VEL,
                                      `AID_ID_BODY, `AID_ID_BODY, `AID_ID_HDG};
    localparam logic [7:0] LENS [6] = '{`AID_LEN_POSVEL, `AID_LEN_POS, `AID_LEN_VEL,
                                       `AID_LEN_BODY_L, `AID_LEN_BODY_S, `AID_LEN_HDG};

    aid_decoder dut (.clk(clk), .rst(rst), .hdr_valid(hdr_valid), .hdr_ready(hdr_ready),
        .hdr_id(hdr_id), .hdr_len(hdr_len), .rx_valid(rx_valid), .rx_ready(rx_ready),
        .rx_data(rx_data), .rd_valid(rd_valid), .rd_ready(rd_ready), .rd_id(rd_id),
        .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data), .tx_last(tx_last),
        .tx_len(tx_len), .upd_valid(upd_valid), .upd_ready(upd_ready),
        .upd_data(upd_data), .drop_pulse(drop_pulse));

    aid_host_model host (.clk(clk), .hdr_valid(hdr_valid), .hdr_ready(hdr_ready),
        .hdr_id(hdr_id), .hdr_len(hdr_len), .rx_valid(rx_valid), .rx_ready(rx_ready),
        .rx_data(rx_data));

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    always @(posedge clk) begin
        if (drop_pulse === 1'b1) drops++;
        cycles++;
        if (cycles == 30000) begin
            errors++;
            wrap_up();
        end
    end

    // ------------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------------
    task automatic check(input logic [511:0] seen, input logic [511:0] exp, input string what);
        samples_checked++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] %0t ns: %s", $time, what);
        end
    endtask : check

    function automatic logic [31:0] w32(input logic [7:0] id, input int o);
        return {host.pb(id, o + 3, 0), host.pb(id, o + 2, 0), host.pb(id, o + 1, 0),
                host.pb(id, o, 0)};
    endfunction : w32

    function automatic aid_pkg::aid_rec_t exp_rec(input logic [7:0] id, input logic [7:0] len);
        aid_pkg::aid_rec_t r;
        r = '0;
        r.kind = aid_pkg::aid_kind_t'(3'(id - `AID_ID_POSVEL));
        for (int k = 0; k < 3; k++) begin
            case (id)
                `AID_ID_POSVEL: begin
                    r.pos[k]   = {w32(id, 8 * k + 4), w32(id, 8 * k)};
                    r.f32[k]   = w32(id, 24 + 4 * k);
                    r.f32[3+k] = w32(id, 36 + 4 * k);
                    r.f32[6+k] = w32(id, 48 + 4 * k);
                end
                `AID_ID_POS: begin
                    r.pos[k]   = {w32(id, 8 * k + 4), w32(id, 8 * k)};
                    r.f32[3+k] = w32(id, 24 + 4 * k);
                end
                `AID_ID_VEL, `AID_ID_BODY: begin
                    r.f32[k]   = w32(id, 4 * k);
                    r.f32[6+k] = w32(id, (len == `AID_LEN_BODY_S) ? 12 : 12 + 4 * k);
                end
                default: begin
                    r.f32[0] = w32(id, 0);
                    r.f32[6] = w32(id, 4);
                end
            endcase
        end
        return r;
    endfunction : exp_rec

    task automatic take(input aid_pkg::aid_rec_t exp);
        int n;
        n = 0;
        @(negedge clk);
        while (upd_valid !== 1'b1 && n < 200) begin
            @(negedge clk);
            n++;
        end
        check({upd_valid, upd_data}, {1'b1, exp}, "filter record differs");
        @(posedge clk);
        upd_ready <= 1'b1;
        @(posedge clk);
        upd_ready <= 1'b0;
    endtask : take

    task automatic rd(input logic [7:0] id, input logic [7:0] len, input bit slow);
        @(posedge clk);
        rd_valid <= 1'b1;
        rd_id    <= id;
        @(negedge clk);
        while (!rd_ready) @(negedge clk);
        @(posedge clk);
        rd_valid <= 1'b0;
        rd_id    <= ~id;
        for (int i = 0; i < int'(len); i++) begin
            @(negedge clk);
            while (tx_valid !== 1'b1) @(negedge clk);
            check({tx_len, tx_last, tx_data}, {len, 1'(i == int'(len) - 1), host.pb(id, i, 0)},
                  "read-back byte differs");
            @(posedge clk);
            if (slow) begin
                tx_ready <= 1'b0;
                @(posedge clk);
                tx_ready <= 1'b1;
            end
        end
    endtask : rd

    // ------------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------------
    task automatic t_unwritten();
        @(posedge clk);
        rd_valid <= 1'b1;
        rd_id    <= `AID_ID_POS;
        @(posedge clk);
        rd_valid <= 1'b0;
        repeat (4) begin
            @(negedge clk);
            check(tx_valid, 1'b0, "empty image was read back");
        end
    endtask : t_unwritten

    task automatic t_all_kinds();
        int d0;
        d0 = drops;
        for (int i = 0; i < 6; i++) begin
            host.send(IDS[i], LENS[i], 0, i[0]);
            take(exp_rec(IDS[i], LENS[i]));
        end
        check(drops - d0, 0, "good packet dropped");
    endtask : t_all_kinds

    // Lengths off the allowed ones (59, 20 and 9), a zero length and an unknown id must all be dropped.
    task automatic t_bad();
        int d0;
        d0 = drops;
        host.send(`AID_ID_POSVEL, 8'h3B, 1, 0);
        host.send(`AID_ID_BODY, 8'h14, 1, 1);
        host.send(`AID_ID_HDG, 8'h09, 1, 0);
        host.send(8'h31, 8'h04, 1, 0);
        host.send(`AID_ID_HDG, 8'h00, 1, 0);
        repeat (4) @(negedge clk);
        check(drops - d0, 5, "bad packets not all dropped");
        check(upd_valid, 1'b0, "bad packet reached filter");
    endtask : t_bad

    // The short body packet and the untouched heading image are read back.
    task automatic t_readback();
        for (int i = 0; i < 6; i++) begin
            if (i != 3) rd(IDS[i], LENS[i], i[0]);
        end
    endtask : t_readback

    // Filter stalls while three records arrive: two wait in the buffer, the decoder holds one.
    task automatic t_buffer();
        host.send(`AID_ID_HDG, `AID_LEN_HDG, 0, 0);
        host.send(`AID_ID_VEL, `AID_LEN_VEL, 0, 0);
        host.send(`AID_ID_POS, `AID_LEN_POS, 0, 1);
        repeat (6) @(negedge clk);
        check({hdr_ready, rd_ready, rx_ready}, 3'h0, "stalled decoder offers input");
        take(exp_rec(`AID_ID_HDG, `AID_LEN_HDG));
        take(exp_rec(`AID_ID_VEL, `AID_LEN_VEL));
        take(exp_rec(`AID_ID_POS, `AID_LEN_POS));
    endtask : t_buffer

    task automatic wrap_up();
        $display("comparisons %0d, mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : wrap_up

    initial begin
        rst       = 1'b1;
        rd_valid  = 1'b0;
        rd_id     = 8'h00;
        tx_ready  = 1'b1;
        upd_ready = 1'b0;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        t_unwritten();
        t_all_kinds();
        t_bad();
        t_readback();
        t_buffer();
        wrap_up();
    end
endmodule : aid_decoder_test
